/* dior_map.vh */
// Constants for the dual interrupt output router: register offsets,
// mask field positions, reset values and tick pulse timing.
// Assumes a 100 MHz clk and an 8-bit register port inside the device.
//
// Summary of operation
// - Clearing the tick flag during a tick pulse ends the pulse one clock after the flag drops.
// - Watchdog interrupt is gated by its enable and follows its flag as a level.
// - Watchdog source never produces a pulse.
// - Watchdog output releases one clock after its flag returns to zero.
// - Alarm source, when enabled and unmasked, follows the alarm flag as a level.
// - Each timestamp channel has its own enable and drives a level from its flag.
// - Switch-over source, when enabled and unmasked, follows its flag as a level.
// - Low-battery interrupt ends only when its flag drops, its enable clears or the pin's mask bit is set.
// - Low-battery flag is read only; host writes never clear it.
// - First mask register bits 5..0: minute, second, watchdog, alarm, switch-over, low battery.
// - Second mask register bits 3..0 mask timestamp channels 1 to 4.
// - Unused upper mask bits always read as zero.
// - Registers 31h/32h serve pin A, 33h/34h serve pin B.
// - A mask bit of one blocks its source from that pin only.
// - Tick pulse lasts one period of an internal 64 Hz clock.
// - Pulse select chooses tick pulse or level held until flag is cleared.
// - Both pins are open-drain, active low, released when all sources disabled.
// - Minute enable alone ticks per minute; second enable ticks per second; neither never.
`ifndef DIOR_MAP_VH
`define DIOR_MAP_VH

`define DIOR_ADDR_A_SRC     8'h31
`define DIOR_ADDR_A_STAMP   8'h32
`define DIOR_ADDR_B_SRC     8'h33
`define DIOR_ADDR_B_STAMP   8'h34

`define DIOR_SRC_W          6
`define DIOR_STAMP_W        4
`define DIOR_SRC_RST        6'h3F
`define DIOR_STAMP_RST      4'hF

`define DIOR_BIT_MIN        5
`define DIOR_BIT_SEC        4
`define DIOR_BIT_WDT        3
`define DIOR_BIT_ALM        2
`define DIOR_BIT_SWO        1
`define DIOR_BIT_LOWB       0

`define DIOR_CLK_HZ         100000000
`define DIOR_PULSE_HZ       64
`define DIOR_PULSE_CYC      (`DIOR_CLK_HZ / `DIOR_PULSE_HZ)
`define DIOR_CNT_W          21

`endif

/* dior_mask_reg.v */
// One mask register pair for one interrupt pin.
// Assumes the register port write strobe is a one-cycle pulse.
`default_nettype none
`include "dior_map.vh"
module dior_mask_reg #(
    parameter [7:0] ADDR_SRC   = `DIOR_ADDR_A_SRC,
    parameter [7:0] ADDR_STAMP = `DIOR_ADDR_A_STAMP
) (
    input  wire                      clk,
    input  wire                      rst,
    input  wire                      wr_en,
    input  wire [7:0]                addr,
    input  wire [7:0]                wdata,
    output reg  [`DIOR_SRC_W-1:0]    src_mask_r,
    output reg  [`DIOR_STAMP_W-1:0]  stamp_mask_r,
    output reg                       hit,
    output reg  [7:0]                rdata
);
    always @(posedge clk) begin
        if (rst) begin
            src_mask_r   <= `DIOR_SRC_RST;
            stamp_mask_r <= `DIOR_STAMP_RST;
        end else if (wr_en && addr == ADDR_SRC) begin
            src_mask_r   <= wdata[`DIOR_SRC_W-1:0];
        end else if (wr_en && addr == ADDR_STAMP) begin
            stamp_mask_r <= wdata[`DIOR_STAMP_W-1:0];
        end
    end

    always @* begin
        hit   = 1'b1;
        rdata = 8'h00;
        if (addr == ADDR_SRC)
            rdata = {2'h0, src_mask_r};
        else if (addr == ADDR_STAMP)
            rdata = {4'h0, stamp_mask_r};
        else
            hit = 1'b0;
    end
endmodule // dior_mask_reg
`default_nettype wire

/* dior_tick_pulse.v */
// Tick pulse shaper: one 64 Hz period long, cut short when the flag clears.
// Assumes tick_set is a one-cycle pulse that also sets the tick flag.
`default_nettype none
`include "dior_map.vh"
module dior_tick_pulse (
    input  wire clk,
    input  wire rst,
    input  wire tick_set,
    input  wire tick_flag,
    output reg  pulse_r
);
    localparam integer           PULSE_LAST_I = `DIOR_PULSE_CYC - 1;
    localparam [`DIOR_CNT_W-1:0] PULSE_LAST   = PULSE_LAST_I[`DIOR_CNT_W-1:0];
    reg [`DIOR_CNT_W-1:0] cnt_r;

    always @(posedge clk) begin
        if (rst) begin
            pulse_r <= 1'b0;
            cnt_r   <= {`DIOR_CNT_W{1'b0}};
        end else if (tick_set) begin
            pulse_r <= 1'b1;
            cnt_r   <= {`DIOR_CNT_W{1'b0}};
        end else if (pulse_r) begin
            // Flag cleared mid-pulse ends it early
            if (!tick_flag || cnt_r == PULSE_LAST)
                pulse_r <= 1'b0;
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // dior_tick_pulse
`default_nettype wire

/* dior_router.v */
// Dual interrupt output router: flags, enables and two mask pairs drive
// two open-drain active-low interrupt pins.
// Assumes flags come from their own logic, except the tick flag kept here;
// register port is the device's internal 8-bit port, one-cycle write strobe.
`default_nettype none
`include "dior_map.vh"
module dior_router (
    input  wire        clk,
    input  wire        rst,
    input  wire        reg_wr,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_hit,
    input  wire        minute_inc,
    input  wire        second_inc,
    input  wire        sixty_second_tick_enable,
    input  wire        one_second_tick_enable,
    input  wire        tick_flag_clear,
    input  wire        tick_pulse_select,
    input  wire        watchdog_irq_enable,
    input  wire        watchdog_flag,
    input  wire        alarm_irq_enable,
    input  wire        alarm_flag,
    input  wire [3:0]  stamp_irq_enables,
    input  wire [3:0]  stamp_flags,
    input  wire        switchover_irq_enable,
    input  wire        switchover_flag,
    input  wire        low_battery_irq_enable,
    input  wire        low_battery_flag,
    output reg         tick_flag,
    output reg         irq_out_a_o,
    output reg         irq_out_a_oe,
    output reg         irq_out_b_o,
    output reg         irq_out_b_oe
);
    wire [`DIOR_SRC_W-1:0]   a_src;
    wire [`DIOR_SRC_W-1:0]   b_src;
    wire [`DIOR_STAMP_W-1:0] a_stamp;
    wire [`DIOR_STAMP_W-1:0] b_stamp;
    wire [7:0]               a_rdata;
    wire [7:0]               b_rdata;
    wire                     a_hit;
    wire                     b_hit;
    wire                     pulse;
    reg                      tick_set;
    reg                      tick_min_act;
    reg                      tick_sec_act;
    reg  [`DIOR_SRC_W-1:0]   src_act;
    reg                      req_a;
    reg                      req_b;

    // Pin A pair at the lower addresses, pin B at the next two
    dior_mask_reg #(
        .ADDR_SRC   (`DIOR_ADDR_A_SRC),
        .ADDR_STAMP (`DIOR_ADDR_A_STAMP)
    ) u_mask_a (
        .clk          (clk),
        .rst          (rst),
        .wr_en        (reg_wr),
        .addr         (reg_addr),
        .wdata        (reg_wdata),
        .src_mask_r   (a_src),
        .stamp_mask_r (a_stamp),
        .hit          (a_hit),
        .rdata        (a_rdata)
    );

    dior_mask_reg #(
        .ADDR_SRC   (`DIOR_ADDR_B_SRC),
        .ADDR_STAMP (`DIOR_ADDR_B_STAMP)
    ) u_mask_b (
        .clk          (clk),
        .rst          (rst),
        .wr_en        (reg_wr),
        .addr         (reg_addr),
        .wdata        (reg_wdata),
        .src_mask_r   (b_src),
        .stamp_mask_r (b_stamp),
        .hit          (b_hit),
        .rdata        (b_rdata)
    );

    // Registered read answer; unmapped addresses read zero
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end else begin
            reg_rdata <= a_rdata | b_rdata;
            reg_hit   <= a_hit | b_hit;
        end
    end

    // Second enable wins over minute enable; neither means no tick
    always @* begin
        if (one_second_tick_enable)
            tick_set = second_inc;
        else if (sixty_second_tick_enable)
            tick_set = minute_inc;
        else
            tick_set = 1'b0;
    end

    // Set wins over a clear arriving in the same cycle
    always @(posedge clk) begin
        if (rst)
            tick_flag <= 1'b0;
        else if (tick_set)
            tick_flag <= 1'b1;
        else if (tick_flag_clear)
            tick_flag <= 1'b0;
    end

    dior_tick_pulse u_pulse (
        .clk       (clk),
        .rst       (rst),
        .tick_set  (tick_set),
        .tick_flag (tick_flag),
        .pulse_r   (pulse)
    );

    // The tick belongs to the minute or second mask by which timer is live
    always @* begin
        tick_min_act = 1'b0;
        tick_sec_act = 1'b0;
        if (tick_pulse_select) begin
            tick_min_act = pulse && !one_second_tick_enable && sixty_second_tick_enable;
            tick_sec_act = pulse && one_second_tick_enable;
        end else begin
            tick_min_act = tick_flag && !one_second_tick_enable && sixty_second_tick_enable;
            tick_sec_act = tick_flag && one_second_tick_enable;
        end
        src_act                 = {`DIOR_SRC_W{1'b0}};
        src_act[`DIOR_BIT_MIN]  = tick_min_act;
        src_act[`DIOR_BIT_SEC]  = tick_sec_act;
        src_act[`DIOR_BIT_WDT]  = watchdog_irq_enable && watchdog_flag;
        src_act[`DIOR_BIT_ALM]  = alarm_irq_enable && alarm_flag;
        src_act[`DIOR_BIT_SWO]  = switchover_irq_enable && switchover_flag;
        // Flag has no clear path here: only the detector drops it
        src_act[`DIOR_BIT_LOWB] = low_battery_irq_enable && low_battery_flag;
    end

    always @* begin
        req_a = |(src_act & ~a_src) | |(stamp_irq_enables & stamp_flags & ~a_stamp);
        req_b = |(src_act & ~b_src) | |(stamp_irq_enables & stamp_flags & ~b_stamp);
    end

    // Open drain: output data is always low, only the enable moves
    always @(posedge clk) begin
        if (rst) begin
            irq_out_a_o  <= 1'b0;
            irq_out_a_oe <= 1'b0;
            irq_out_b_o  <= 1'b0;
            irq_out_b_oe <= 1'b0;
        end else begin
            irq_out_a_o  <= 1'b0;
            irq_out_a_oe <= req_a;
            irq_out_b_o  <= 1'b0;
            irq_out_b_oe <= req_b;
        end
    end
endmodule // dior_router
`default_nettype wire

/* dior_router_monitor.sv */
// Assertion checker for dior_router, bound to every instance.
// Sees only the router's ports; mask state is judged through the register port.
`default_nettype none
module dior_router_monitor (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_hit,
    input wire logic       minute_inc,
    input wire logic       second_inc,
    input wire logic       tick_flag_clear,
    input wire logic       tick_flag,
    input wire logic       sixty_second_tick_enable,
    input wire logic       one_second_tick_enable,
    input wire logic       watchdog_irq_enable,
    input wire logic       watchdog_flag,
    input wire logic       alarm_irq_enable,
    input wire logic       alarm_flag,
    input wire logic       switchover_irq_enable,
    input wire logic       switchover_flag,
    input wire logic       low_battery_irq_enable,
    input wire logic       low_battery_flag,
    input wire logic       irq_out_a_o,
    input wire logic       irq_out_a_oe,
    input wire logic       irq_out_b_o,
    input wire logic       irq_out_b_oe,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] stamp_irq_enables,
    input wire logic [3:0] stamp_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire tick_set = (minute_inc & sixty_second_tick_enable & ~one_second_tick_enable)
                  | (second_inc & one_second_tick_enable);
    wire src_any = tick_flag | (watchdog_irq_enable & watchdog_flag) | (alarm_irq_enable & alarm_flag)
                 | (|(stamp_irq_enables & stamp_flags)) | (switchover_irq_enable & switchover_flag)
                 | (low_battery_irq_enable & low_battery_flag);
    wire mapped  = reg_addr >= 8'h31 && reg_addr <= 8'h34;
    wire src_reg = reg_addr[0];
    // Pulse mode needs two cycles to drop after the flag, hence the two-deep look back
    quiet_pin_a_a: assert property (!$past(src_any) && !$past(src_any, 2) |-> !irq_out_a_oe)
        else $error("pin A asserted with no active source");
    quiet_pin_b_a: assert property (!$past(src_any) && !$past(src_any, 2) |-> !irq_out_b_oe)
        else $error("pin B asserted with no active source");
    open_drain_a: assert property (!irq_out_a_o && !irq_out_b_o) else $error("pin data not low");
    hit_map_a: assert property (!$past(rst) |-> reg_hit == $past(mapped)) else $error("hit flag wrong");
    unmapped_zero_a: assert property (!reg_hit |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    // Read port is registered: the written value shows two edges after the write edge
    mask_write_a: assert property (reg_wr && mapped ##1 reg_addr == $past(reg_addr) |=>
        reg_rdata == ($past(reg_wdata, 2) & ($past(src_reg, 2) ? 8'h3F : 8'h0F))) else $error("mask readback wrong");
    tick_set_a: assert property (tick_set |=> tick_flag) else $error("tick flag not set");
    tick_quiet_a: assert property (!tick_flag && !sixty_second_tick_enable && !one_second_tick_enable
        |=> !tick_flag) else $error("tick flag set while disabled");
    tick_clear_a: assert property (tick_flag_clear && !tick_set |=> !tick_flag) else $error("tick flag not cleared");
    cover property (irq_out_a_oe ##1 !irq_out_a_oe);
    cover property (irq_out_b_oe);
    cover property ($fell(tick_flag) ##3 !irq_out_a_oe);
endmodule // dior_router_monitor
bind dior_router dior_router_monitor u_mon (.*);
`default_nettype wire

/* dior_host_model.sv */
// Host side of the two interrupt lines: pull-ups resolve the open-drain pins.
// Assumes each pin is driven by the router alone.
`default_nettype none
module dior_host_model (
    input  wire logic irq_out_a_o,
    input  wire logic irq_out_a_oe,
    input  wire logic irq_out_b_o,
    input  wire logic irq_out_b_oe,
    output wire logic irq_a_n,
    output wire logic irq_b_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released line goes to the pull-up level, never the last driven value
    assign irq_a_n = irq_out_a_oe ? irq_out_a_o : 1'b1;
    assign irq_b_n = irq_out_b_oe ? irq_out_b_o : 1'b1;
endmodule // dior_host_model
`default_nettype wire

/* tb_dior_router.sv */
// Testbench for dior_router: random mask traffic, every level source and the tick paths.
// Assumes dior_host_model resolves the open-drain pins; all stimulus moves on the falling edge.
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_dior_router;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, rst = 1, wr = 0, mi = 0, si = 0, me = 0, se = 0, tclr = 0, tps = 0, p;
    logic [7:0] addr = 8'h00, wd = 8'h00, en = 8'h00, fl = 8'h00, rd, a, sm, tm;
    logic       hit, tf, ao, aoe, bo, boe;
    wire        pa_n, pb_n;
    logic [15:0] lf = 16'h6352;
    int         errors = 0, checks_done = 0, i, k;
    always #5 clk = ~clk;
    dior_router u_dut (.clk(clk), .rst(rst), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd),
        .reg_hit(hit), .minute_inc(mi), .second_inc(si), .sixty_second_tick_enable(me),
        .one_second_tick_enable(se), .tick_flag_clear(tclr), .tick_pulse_select(tps),
        .watchdog_irq_enable(en[7]), .watchdog_flag(fl[7]), .alarm_irq_enable(en[6]), .alarm_flag(fl[6]),
        .stamp_irq_enables(en[3:0]), .stamp_flags(fl[3:0]), .switchover_irq_enable(en[5]),
        .switchover_flag(fl[5]), .low_battery_irq_enable(en[4]), .low_battery_flag(fl[4]), .tick_flag(tf),
        .irq_out_a_o(ao), .irq_out_a_oe(aoe), .irq_out_b_o(bo), .irq_out_b_oe(boe));
    dior_host_model u_host (.irq_out_a_o(ao), .irq_out_a_oe(aoe), .irq_out_b_o(bo), .irq_out_b_oe(boe),
        .irq_a_n(pa_n), .irq_b_n(pb_n));
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Odd offsets hold the six source masks, even ones the four stamp masks
    function automatic logic [7:0] rb(input logic [7:0] ad, v);
        return ad[0] ? {2'h0, v[5:0]} : {4'h0, v[3:0]};
    endfunction
    task wreg(input logic [7:0] ad, v);
        @(negedge clk); addr = ad; wd = v; wr = 1'b1;
        @(negedge clk); wr = 1'b0;
    endtask
    task rchk(input logic [7:0] ad, e);
        @(negedge clk); addr = ad;
        @(negedge clk); `CHK("rdata", e, rd)
    endtask
    task pins(input int n, input logic [1:0] e);
        repeat (n) @(negedge clk);
        `CHK("pins", e, {pa_n, pb_n})
    endtask
    task strobe(input logic [2:0] w);
        {mi, si, tclr} = w;
        @(negedge clk); {mi, si, tclr} = 3'h0;
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (i = 8'h31; i <= 8'h35; i++) rchk(i[7:0], i == 8'h35 ? 8'h00 : rb(i[7:0], 8'hFF));
        `CHK("hit", 1'b0, hit)
        `CHK("pins", 2'b11, {pa_n, pb_n})
        $display("reset values done");
        for (i = 0; i < 24; i++) begin
            lf = nx(lf); a = 8'h31 + {6'h00, lf[1:0]};
            wreg(a, lf[15:8]); rchk(a, rb(a, lf[15:8]));
            `CHK("hit", 1'b1, hit)
        end
        $display("mask traffic done");
        for (i = 0; i < 32; i++) begin
            k = i % 8; lf = nx(lf); p = lf[0];
            sm = k >= 4 ? ~(8'h01 << (k - 4)) : 8'hFF;
            tm = k < 4 ? ~(8'h01 << k) : 8'hFF;
            // Other sources see random enables and flags but stay masked on both pins
            wreg(8'h31, p ? 8'hFF : sm); wreg(8'h32, p ? 8'hFF : tm);
            wreg(8'h33, p ? sm : 8'hFF); wreg(8'h34, p ? tm : 8'hFF);
            en = lf[15:8] | (8'h01 << k); fl = lf[7:0] | (8'h01 << k);
            pins(1, {p, ~p});
            fl[k] = 1'b0; pins(1, 2'b11);
            fl[k] = 1'b1; en[k] = 1'b0; pins(1, 2'b11);
            en = 8'h00; fl = 8'h00;
        end
        $display("level sources done");
        wreg(8'h31, 8'hEF); wreg(8'h33, 8'hFF);
        se = 1'b1;
        for (i = 0; i < 2; i++) begin
            tps = i[0]; strobe(3'h2); pins(3, 2'b01);
            `CHK("tick_flag", 1'b1, tf)
            strobe(3'h1); pins(3, 2'b11);
        end
        se = 1'b0; me = 1'b1; wreg(8'h31, 8'hDF);
        strobe(3'h2); pins(3, 2'b11);
        strobe(3'h4); pins(3, 2'b01);
        strobe(3'h1); pins(3, 2'b11);
        $display("tick paths done");
        results;
    end
endmodule // tb_dior_router
`default_nettype wire
